// ==== rtl/i2c_slave_irq_enable_status.sv ====
// Operation
// - Overrun flag with enable bit 9 interrupts.
// - General call flag with bit 8 interrupts.
// - NACK flag with bit 7 interrupts.
// - Address match flag with bit 5 interrupts.
// - Timeout flag with bit 4 interrupts.
// - Clock stretch flag with bit 3 interrupts.
// - Receive ready flag with bit 2 interrupts.
// - Transmit complete flag with bit 1 interrupts.
// - START flag with bit 0 interrupts.
// - STOP sets sticky bit 5; software set interrupts.
// - START plus two clocks sets bit 4.
// - Memory address byte fills pointer, sets bit 3.
// - Byte out and acknowledge sets bit 1.
// - STOP flag gated by second enable bit 5.
// - First write byte after match is address.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_irq_enable_status (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire i2c_irq_pkg::reg_req_t REG_REQ_I,
    output logic [i2c_irq_pkg::DATA_W-1:0] RDATA_O,
    input wire i2c_irq_pkg::pri_flags_t PRI_FLAGS_I,
    input wire i2c_irq_pkg::link_event_t LINK_EVT_I,
    input wire logic SCL_I,
    output logic [i2c_irq_pkg::MEM_PTR_W-1:0] MEM_PTR_O,
    output logic IRQ_O
);

    // True when the request address selects the given register offset.
    function automatic logic addr_hit(
        input logic [i2c_irq_pkg::ADDR_W-1:0] addr,
        input logic [i2c_irq_pkg::ADDR_W-1:0] off
    );
        addr_hit = (addr == off);
    endfunction

    // Primary interrupt enable register; reserved bits are never stored.
    i2c_irq_pkg::pri_flags_t irq_enable;
    // Secondary interrupt enable register, masked to its writable bits.
    logic [i2c_irq_pkg::DATA_W-1:0] irq_enable2;
    // Secondary status register, driven by the sticky flag bank.
    logic [i2c_irq_pkg::DATA_W-1:0] status2;
    // Hardware set requests for the secondary status bits.
    logic [i2c_irq_pkg::DATA_W-1:0] status2_set;
    // Memory pointer low byte.
    logic [i2c_irq_pkg::MEM_PTR_W-1:0] mem_ptr;
    // Registered read data, valid only in the cycle after a read.
    logic [i2c_irq_pkg::DATA_W-1:0] rdata;
    // Registered interrupt request.
    logic irq;

    // Clock line after the synchroniser, and its value one cycle earlier.
    logic scl_s;
    logic scl_d;

    // Tracker states.
    i2c_irq_pkg::after_start_state_t as_state;
    i2c_irq_pkg::after_start_state_t next_as_state;
    i2c_irq_pkg::mem_addr_state_t ma_state;
    i2c_irq_pkg::mem_addr_state_t next_ma_state;

    // Write strobes decoded per register.
    wire logic wr_enable = REG_REQ_I.wr && addr_hit(REG_REQ_I.addr, i2c_irq_pkg::OFF_IRQ_ENABLE);
    wire logic wr_status2 = REG_REQ_I.wr && addr_hit(REG_REQ_I.addr, i2c_irq_pkg::OFF_STATUS2);
    wire logic wr_enable2 = REG_REQ_I.wr && addr_hit(REG_REQ_I.addr, i2c_irq_pkg::OFF_IRQ_ENABLE2);
    wire logic wr_mem_ptr = REG_REQ_I.wr && addr_hit(REG_REQ_I.addr, i2c_irq_pkg::OFF_MEM_PTR);

    // Rising edge of the synchronised clock line.
    wire logic scl_rise = scl_s && !scl_d;

    // The memory address byte is the first byte received while armed.
    wire logic mem_addr_catch = (ma_state == i2c_irq_pkg::MA_ARMED) && LINK_EVT_I.rx_valid;

    // The second rising clock edge after START completes the after-start sequence.
    // A START or STOP in the same cycle wins, since either one ends the count.
    wire logic after_start_hit = (as_state == i2c_irq_pkg::AS_ONE) && scl_rise
        && !LINK_EVT_I.start && !LINK_EVT_I.stop;

    // Primary flags gated bit by bit with their enables.
    wire logic [i2c_irq_pkg::PRI_W-1:0] pri_hits = PRI_FLAGS_I & irq_enable;

    // Secondary flags gated with the secondary enables; the transfer flag has no enable.
    wire logic [i2c_irq_pkg::DATA_W-1:0] sec_hits = status2 & irq_enable2;

    // Any enabled source raises the single request.
    wire logic next_irq = (|pri_hits) || (|sec_hits);

    // Read selection; unmapped offsets and reserved bits read as zero.
    wire logic [i2c_irq_pkg::DATA_W-1:0] read_mux =
        addr_hit(REG_REQ_I.addr, i2c_irq_pkg::OFF_IRQ_ENABLE) ? i2c_irq_pkg::DATA_W'(irq_enable) :
        addr_hit(REG_REQ_I.addr, i2c_irq_pkg::OFF_STATUS2) ? status2 :
        addr_hit(REG_REQ_I.addr, i2c_irq_pkg::OFF_IRQ_ENABLE2) ? irq_enable2 :
        addr_hit(REG_REQ_I.addr, i2c_irq_pkg::OFF_MEM_PTR) ? i2c_irq_pkg::DATA_W'(mem_ptr) :
        i2c_irq_pkg::REG_RESET;

    // The clock line comes from the far master, so it is synchronised first.
    bit_sync2 #(
        .RESET_LEVEL(i2c_irq_pkg::SCL_IDLE)
    ) u_scl_sync (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .d_i(SCL_I),
        .q_o(scl_s)
    );

    // Hardware set requests for each secondary status bit; reserved bits never set.
    always_comb
    begin
        status2_set = i2c_irq_pkg::REG_RESET;
        status2_set[i2c_irq_pkg::BIT_STOP] = LINK_EVT_I.stop;
        status2_set[i2c_irq_pkg::BIT_AFTER_START] = after_start_hit;
        status2_set[i2c_irq_pkg::BIT_MEM_ADDR] = mem_addr_catch;
        status2_set[i2c_irq_pkg::BIT_XFER_DONE] = LINK_EVT_I.tx_acked;
    end

    // Secondary status flags; a software write of one also sets a flag,
    // so software can raise the interrupt itself for test.
    sticky_flags #(
        .W(i2c_irq_pkg::DATA_W)
    ) u_status2 (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .hw_set_i(status2_set),
        .sw_we_i(wr_status2),
        .sw_val_i(REG_REQ_I.wdata & i2c_irq_pkg::STATUS2_RW_MASK),
        .q_o(status2)
    );

    // After-start tracker. A repeated START restarts the count, and a STOP
    // abandons it. Edges are counted only after synchronisation, so the
    // flag lags the bus by the two synchroniser stages.
    always_comb
    begin
        next_as_state = as_state;
        if (LINK_EVT_I.start)
            next_as_state = i2c_irq_pkg::AS_ZERO;
        else if (LINK_EVT_I.stop)
            next_as_state = i2c_irq_pkg::AS_IDLE;
        else
        begin
            unique case (as_state)
                // Nothing to count until a START.
                i2c_irq_pkg::AS_IDLE:
                    next_as_state = i2c_irq_pkg::AS_IDLE;
                // First rising edge after START.
                i2c_irq_pkg::AS_ZERO:
                    if (scl_rise)
                        next_as_state = i2c_irq_pkg::AS_ONE;
                // Second rising edge sets the flag and ends the sequence.
                i2c_irq_pkg::AS_ONE:
                    if (scl_rise)
                        next_as_state = i2c_irq_pkg::AS_IDLE;
                // The spare code falls back to idle.
                default:
                    next_as_state = i2c_irq_pkg::AS_IDLE;
            endcase
        end
    end

    // Memory address catcher. Armed by a write address match, disarmed by the
    // first byte or by any START or STOP, so read transfers never move the pointer.
    always_comb
    begin
        next_ma_state = ma_state;
        unique case (ma_state)
            // Wait for an address match with the write direction.
            i2c_irq_pkg::MA_IDLE:
                if (LINK_EVT_I.addr_match_wr && !LINK_EVT_I.stop)
                    next_ma_state = i2c_irq_pkg::MA_ARMED;
            // The next byte, or a bus condition, ends the wait.
            i2c_irq_pkg::MA_ARMED:
                if (LINK_EVT_I.rx_valid || LINK_EVT_I.start || LINK_EVT_I.stop)
                    next_ma_state = i2c_irq_pkg::MA_IDLE;
        endcase
    end

    // Tracker states and the delayed clock sample.
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
        begin
            as_state <= i2c_irq_pkg::AS_IDLE;
            ma_state <= i2c_irq_pkg::MA_IDLE;
            scl_d <= i2c_irq_pkg::SCL_IDLE;
        end
        else if (CE_I)
        begin
            as_state <= next_as_state;
            ma_state <= next_ma_state;
            scl_d <= scl_s;
        end
    end

    // Enable registers; reserved bits are masked off so they read as zero.
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
        begin
            irq_enable <= i2c_irq_pkg::REG_RESET[i2c_irq_pkg::PRI_W-1:0];
            irq_enable2 <= i2c_irq_pkg::REG_RESET;
        end
        else if (CE_I)
        begin
            if (wr_enable)
                irq_enable <= REG_REQ_I.wdata[i2c_irq_pkg::PRI_W-1:0] & i2c_irq_pkg::PRI_EN_MASK;
            if (wr_enable2)
                irq_enable2 <= REG_REQ_I.wdata & i2c_irq_pkg::ENABLE2_RW_MASK;
        end
    end

    // Memory pointer; the captured bus byte wins over a software write in the same cycle.
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            mem_ptr <= i2c_irq_pkg::MEM_PTR_RESET;
        else if (CE_I)
        begin
            if (mem_addr_catch)
                mem_ptr <= LINK_EVT_I.rx_byte;
            else if (wr_mem_ptr)
                mem_ptr <= REG_REQ_I.wdata[i2c_irq_pkg::MEM_PTR_W-1:0];
        end
    end

    // Read data stands only in the cycle after the read strobe, zero otherwise.
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            rdata <= i2c_irq_pkg::REG_RESET;
        else if (CE_I)
            rdata <= REG_REQ_I.rd ? read_mux : i2c_irq_pkg::REG_RESET;
    end

    // Registered interrupt request; one cycle of latency buys a glitch-free output.
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            irq <= 1'b0;
        else if (CE_I)
            irq <= next_irq;
    end

    assign RDATA_O = rdata;
    assign MEM_PTR_O = mem_ptr;
    assign IRQ_O = irq;

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_N_I);

    // Each enabled primary flag must reach the request one edge later.
    AST_OVERRUN_IRQ: assert property (
        CE_I && PRI_FLAGS_I.overrun && irq_enable.overrun |=> IRQ_O)
        else $error("Overrun flag with enable did not raise the interrupt.");
    AST_GCALL_IRQ: assert property (
        CE_I && PRI_FLAGS_I.general_call && irq_enable.general_call |=> IRQ_O)
        else $error("General call flag with enable did not raise the interrupt.");
    AST_NACK_IRQ: assert property (
        CE_I && PRI_FLAGS_I.nack && irq_enable.nack |=> IRQ_O)
        else $error("NACK flag with enable did not raise the interrupt.");
    AST_MATCH_IRQ: assert property (
        CE_I && PRI_FLAGS_I.addr_match && irq_enable.addr_match |=> IRQ_O)
        else $error("Address match flag with enable did not raise the interrupt.");
    AST_TIMEOUT_IRQ: assert property (
        CE_I && PRI_FLAGS_I.timeout && irq_enable.timeout |=> IRQ_O)
        else $error("Timeout flag with enable did not raise the interrupt.");
    AST_STRETCH_IRQ: assert property (
        CE_I && PRI_FLAGS_I.stretch && irq_enable.stretch |=> IRQ_O)
        else $error("Stretch flag with enable did not raise the interrupt.");
    AST_RXRDY_IRQ: assert property (
        CE_I && PRI_FLAGS_I.rx_ready && irq_enable.rx_ready |=> IRQ_O)
        else $error("Receive ready flag with enable did not raise the interrupt.");
    AST_TXDONE_IRQ: assert property (
        CE_I && PRI_FLAGS_I.tx_done && irq_enable.tx_done |=> IRQ_O)
        else $error("Transmit complete flag with enable did not raise the interrupt.");
    AST_START_IRQ: assert property (
        CE_I && PRI_FLAGS_I.start && irq_enable.start |=> IRQ_O)
        else $error("START flag with enable did not raise the interrupt.");
    // Register reads and the secondary status flags. The pointer read is left out
    // here because its low byte legitimately covers reserved enable bit 6.
    AST_RESERVED_ZERO: assert property (
        CE_I && REG_REQ_I.rd && !addr_hit(REG_REQ_I.addr, i2c_irq_pkg::OFF_MEM_PTR)
            |=> (RDATA_O & ~i2c_irq_pkg::DATA_W'(i2c_irq_pkg::PRI_EN_MASK)
            & ~i2c_irq_pkg::STATUS2_RW_MASK) == i2c_irq_pkg::REG_RESET)
        else $error("Reserved bits read back non-zero.");
    AST_STOP_STICKY: assert property (
        CE_I && LINK_EVT_I.stop |=> status2[i2c_irq_pkg::BIT_STOP]
            ##1 (status2[i2c_irq_pkg::BIT_STOP] || $past(wr_status2) || !$past(CE_I)))
        else $error("STOP flag did not set or did not hold.");
    AST_AFTER_START: assert property (
        CE_I && LINK_EVT_I.start ##1 (!LINK_EVT_I.start && !LINK_EVT_I.stop && CE_I
            && !scl_rise)[*2] |-> as_state == i2c_irq_pkg::AS_ZERO
            && !status2_set[i2c_irq_pkg::BIT_AFTER_START])
        else $error("After-start flag set too early.");
    AST_MEM_ADDR: assert property (
        CE_I && mem_addr_catch |=> mem_ptr == $past(LINK_EVT_I.rx_byte)
            && status2[i2c_irq_pkg::BIT_MEM_ADDR])
        else $error("Memory address byte not captured with its flag.");
    AST_XFER_DONE: assert property (
        CE_I && LINK_EVT_I.tx_acked |=> status2[i2c_irq_pkg::BIT_XFER_DONE])
        else $error("Transfer done flag not set after acknowledge.");
    AST_STOP_GATE: assert property (
        CE_I && status2[i2c_irq_pkg::BIT_STOP] && irq_enable2[i2c_irq_pkg::BIT_STOP] |=> IRQ_O)
        else $error("Enabled STOP flag did not raise the interrupt.");
    AST_MEM_ARM: assert property (
        CE_I && ma_state == i2c_irq_pkg::MA_IDLE && LINK_EVT_I.addr_match_wr && !LINK_EVT_I.stop
            |=> ma_state == i2c_irq_pkg::MA_ARMED)
        else $error("Write address match did not arm memory address capture.");
    AST_IRQ_QUIET: assert property (
        CE_I && !(|pri_hits) && !(|sec_hits) |=> !IRQ_O)
        else $error("Interrupt raised with no enabled flag set.");
    AST_AFTER_START_SET: assert property (
        CE_I && after_start_hit |=> status2[i2c_irq_pkg::BIT_AFTER_START])
        else $error("After-start flag did not set.");
    AST_PTR_SW_WRITE: assert property (
        CE_I && wr_mem_ptr && !mem_addr_catch
            |=> mem_ptr == $past(REG_REQ_I.wdata[i2c_irq_pkg::MEM_PTR_W-1:0]))
        else $error("Software pointer write did not land.");
    AST_RDATA_IDLE: assert property (
        CE_I && !REG_REQ_I.rd |=> RDATA_O == i2c_irq_pkg::REG_RESET)
        else $error("Read data stood outside a read cycle.");
    // A low clock enable must freeze the visible state, flags included.
    AST_CE_FREEZE: assert property (
        !CE_I |=> $stable(status2) && $stable(mem_ptr) && $stable(IRQ_O))
        else $error("State moved while the clock enable was low.");

    // Main scenarios that the bench is expected to reach.
    COV_STOP_IRQ: cover property (CE_I && LINK_EVT_I.stop && irq_enable2[i2c_irq_pkg::BIT_STOP]
        ##2 IRQ_O);
    COV_MEM_CAPTURE: cover property (LINK_EVT_I.addr_match_wr ##[1:40] mem_addr_catch);
    COV_AFTER_START: cover property (LINK_EVT_I.start ##[1:200] after_start_hit);
    COV_READBACK: cover property (REG_REQ_I.rd ##1 RDATA_O != i2c_irq_pkg::REG_RESET);
    COV_CE_FREEZE: cover property (!CE_I ##1 CE_I);

endmodule
`default_nettype wire

// ==== include/i2c_irq_pkg.sv ====
package i2c_irq_pkg;

    // Width of every software-visible register.
    localparam int unsigned DATA_W = 16;
    // Width of the register port address.
    localparam int unsigned ADDR_W = 3;

    // Register offsets on the plain register port.
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_STATUS2 = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE2 = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_MEM_PTR = 3'h3;

    // Primary flags, most significant first, laid out as the enable register bits 9 down to 0.
    typedef struct packed {
        logic overrun;
        logic general_call;
        logic nack;
        logic unused6;
        logic addr_match;
        logic timeout;
        logic stretch;
        logic rx_ready;
        logic tx_done;
        logic start;
    } pri_flags_t;

    // Number of implemented low bits of the primary enable register.
    localparam int unsigned PRI_W = 10;
    // Writable bits of the primary enable register; bit 6 is reserved.
    localparam logic [PRI_W-1:0] PRI_EN_MASK = 10'h3bf;

    // Secondary status bit positions.
    localparam int unsigned BIT_STOP = 5;
    localparam int unsigned BIT_AFTER_START = 4;
    localparam int unsigned BIT_MEM_ADDR = 3;
    localparam int unsigned BIT_XFER_DONE = 1;

    // Writable bits of the secondary status and secondary enable registers.
    localparam logic [DATA_W-1:0] STATUS2_RW_MASK = 16'h003a;
    localparam logic [DATA_W-1:0] ENABLE2_RW_MASK = 16'h0038;
    // Reset value shared by all registers of the block.
    localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

    // Memory pointer width and its reset value.
    localparam int unsigned MEM_PTR_W = 8;
    localparam logic [MEM_PTR_W-1:0] MEM_PTR_RESET = 8'h00;

    // Level of an idle clock line.
    localparam logic SCL_IDLE = 1'b1;

    // After-start tracker: waiting, START seen, one clock rising edge seen.
    typedef enum logic [1:0] {
        AS_IDLE = 2'b00,
        AS_ZERO = 2'b01,
        AS_ONE = 2'b10
    } after_start_state_t;

    // Memory address catcher: idle, or armed by a write address match.
    typedef enum logic {
        MA_IDLE = 1'b0,
        MA_ARMED = 1'b1
    } mem_addr_state_t;

    // One register port request.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // One-cycle events from the shifter and condition detectors.
    typedef struct packed {
        logic stop;
        logic start;
        logic tx_acked;
        logic addr_match_wr;
        logic rx_valid;
        logic [MEM_PTR_W-1:0] rx_byte;
    } link_event_t;

endpackage

// ==== rtl/bit_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for a level from outside the clock domain.
module bit_sync2 #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic d_i,
    output logic q_o
);

    // First stage; only the second stage reads it, to contain metastability.
    logic meta;

    // Both stages freeze with the clock enable and reset to the idle level.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            meta <= RESET_LEVEL;
            q_o <= RESET_LEVEL;
        end
        else if (ce_i)
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/sticky_flags.sv ====
`timescale 1ns/1ps
`default_nettype none

// Bank of sticky flags: hardware sets, software writes, a set beats a clear.
module sticky_flags #(
    parameter int unsigned W = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] hw_set_i,
    input wire logic sw_we_i,
    input wire logic [W-1:0] sw_val_i,
    output logic [W-1:0] q_o
);

    genvar i;

    // One flop per flag so that each bit keeps its own set-over-clear priority.
    generate
        for (i = 0; i < W; i++)
        begin : g_flag
            // Software value when written, else hold; a hardware set overrides both.
            wire logic next_q = hw_set_i[i] | (sw_we_i ? sw_val_i[i] : q_o[i]);

            always_ff @(posedge clk_i)
            begin
                if (!rst_n_i)
                    q_o[i] <= 1'b0;
                else if (ce_i)
                    q_o[i] <= next_q;
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ==== tb/i2c_scl_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Far-side bus master: it makes SCL pulses only inside a frame.
module i2c_scl_master_model #(
    parameter int HALF_NS = 80
) (
    output logic scl_o
);
    // Between frames the line rests at its pulled-up level, so no edge is seen.
    initial scl_o = 1'b1;

    // Gives n whole clock periods; a non-zero stretch makes a slow master.
    task automatic clocks(input int n, input int stretch);
        // Step off the system clock's sampling edge before the first change.
        #1;
        repeat (n)
        begin
            #(HALF_NS + stretch) scl_o = 1'b0;
            #(HALF_NS) scl_o = 1'b1;
        end
    endtask
endmodule

`default_nettype wire

// ==== tb/i2c_slave_irq_enable_status_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the interrupt enable and secondary status logic.
module i2c_slave_irq_enable_status_bench;
    logic clk = 1'b0; // System clock, 200 MHz.
    logic rst_n = 1'b0; // Synchronous reset, active low.
    logic ce = 1'b1; // Clock enable, dropped once to freeze the block.
    i2c_irq_pkg::reg_req_t req = '0; // Register port request.
    i2c_irq_pkg::pri_flags_t flags = '0; // Primary flags from outside.
    i2c_irq_pkg::link_event_t evt = '0; // One-cycle bus events.
    i2c_irq_pkg::link_event_t e; // Event being built.
    logic scl; // Bus clock from the far-side model.
    logic [15:0] rdata; // Read data.
    logic [7:0] ptr; // Memory pointer.
    logic irq; // Interrupt request.
    logic [15:0] en = '0; // Expected primary enable contents.
    logic [15:0] en2 = '0; // Expected secondary enable contents.
    logic [15:0] st2 = '0; // Expected secondary status contents.
    logic [15:0] v; // Scratch value.
    logic [7:0] b; // Scratch byte.
    int n_errors = 0; // Mismatches seen.
    int checks_done = 0; // Comparisons made.
    integer seed = 63; // Fixed seed keeps the run repeatable.

    // Half period of 2.5 ns gives 200 MHz.
    always #2.5 clk = ~clk;

    i2c_slave_irq_enable_status uut (
        .MCLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .REG_REQ_I(req), .RDATA_O(rdata),
        .PRI_FLAGS_I(flags), .LINK_EVT_I(evt), .SCL_I(scl), .MEM_PTR_O(ptr), .IRQ_O(irq)
    );

    i2c_scl_master_model #(.HALF_NS(80)) drv (.scl_o(scl));

    // Compares a register word.
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string s);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    // Compares a single output bit.
    task automatic chk_bit(input logic got, input logic exp, input string s);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, s, got, exp);
        end
    endtask

    // One write cycle; the strobe drops at the edge that takes it.
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    // One read cycle; data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Register writes that also keep the expected contents; reserved bits drop.
    task automatic set_en(input logic [15:0] d);
        wr_reg(3'h0, d);
        en = d & 16'h03bf;
    endtask
    task automatic set_en2(input logic [15:0] d);
        wr_reg(3'h2, d);
        en2 = d & 16'h0038;
    endtask
    task automatic set_st2(input logic [15:0] d);
        wr_reg(3'h1, d);
        st2 = d & 16'h003a;
    endtask

    // Drives one event for a single cycle.
    task automatic pulse_evt(input i2c_irq_pkg::link_event_t x);
        @(posedge clk);
        evt <= x;
        @(posedge clk);
        evt <= '0;
    endtask

    // Every flag is gated by its own enable; status bit 1 has no enable.
    function automatic logic exp_irq();
        return (|(en & {6'h00, 10'(flags)})) | (|(st2 & en2 & 16'h0038));
    endfunction

    // The request is registered, so two edges pass before it is looked at.
    task automatic check_irq();
        repeat (2) @(posedge clk);
        #1 chk_bit(irq, exp_irq(), "irq");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial
    begin
        #200000;
        n_errors++;
        end_sim();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, then two unmapped places.
        for (int a = 0; a < 6; a++)
        begin
            rd_reg(a[2:0], v);
            chk_word(v, 16'h0000, "reset");
        end
        // Reserved bits read zero even when written.
        set_en(16'hffff);
        rd_reg(3'h0, v);
        chk_word(v, en, "enable");
        set_en(16'h0000);
        set_st2(16'hffff);
        rd_reg(3'h1, v);
        chk_word(v, st2, "status2");
        check_irq();
        set_st2(16'h0000);
        // One enable at a time: every other flag set, then its own flag alone.
        for (int i = 0; i < 10; i++)
        begin
            set_en(16'h0001 << i);
            @(posedge clk);
            flags <= i2c_irq_pkg::pri_flags_t'(~(10'h001 << i));
            check_irq();
            @(posedge clk);
            flags <= i2c_irq_pkg::pri_flags_t'(10'h001 << i);
            check_irq();
        end
        // Random enables against random flags.
        repeat (30)
        begin
            set_en(16'($random(seed)));
            @(posedge clk);
            flags <= i2c_irq_pkg::pri_flags_t'($random(seed));
            check_irq();
        end
        @(posedge clk);
        flags <= '0;
        set_en(16'h0000);
        // A software set of a sticky bit interrupts only when enabled.
        for (int i = 3; i < 6; i++)
        begin
            set_en2(16'h0001 << i);
            set_st2(16'h0001 << i);
            check_irq();
            set_en2(16'h0000);
            check_irq();
            set_st2(16'h0000);
        end
        // A STOP sets a sticky bit, which holds until cleared.
        set_en2(16'h0020);
        e = '0;
        e.stop = 1'b1;
        pulse_evt(e);
        st2[5] = 1'b1;
        check_irq();
        rd_reg(3'h1, v);
        chk_word(v, st2, "stop");
        set_st2(16'h0000);
        check_irq();
        // Transfer done sets bit 1, which never interrupts.
        e = '0;
        e.tx_acked = 1'b1;
        pulse_evt(e);
        st2[1] = 1'b1;
        set_en2(16'hffff);
        rd_reg(3'h1, v);
        chk_word(v, st2, "xfer");
        check_irq();
        set_st2(16'h0000);
        // First byte after a write match is the memory address.
        b = 8'($random(seed));
        e = '0;
        e.addr_match_wr = 1'b1;
        pulse_evt(e);
        e = '0;
        e.rx_valid = 1'b1;
        e.rx_byte = b;
        pulse_evt(e);
        st2[3] = 1'b1;
        check_irq();
        chk_word(16'(ptr), 16'(b), "pointer");
        e.rx_byte = ~b;
        pulse_evt(e);
        rd_reg(3'h3, v);
        chk_word(v, 16'(b), "second byte");
        rd_reg(3'h1, v);
        chk_word(v, st2, "memaddr");
        set_st2(16'h0000);
        // START, then one bus clock, then a slow second one.
        set_en2(16'h0010);
        e = '0;
        e.start = 1'b1;
        pulse_evt(e);
        drv.clocks(1, 0);
        repeat (8) @(posedge clk);
        rd_reg(3'h1, v);
        chk_word(v, 16'h0000, "one clock");
        drv.clocks(1, 40);
        repeat (8) @(posedge clk);
        rd_reg(3'h1, v);
        st2[4] = 1'b1;
        chk_word(v, st2, "two clocks");
        check_irq();
        // A frozen clock enable drops a write; a software pointer write lands.
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(3'h0, 16'h03bf);
        ce <= 1'b1;
        wr_reg(3'h3, 16'h00c5);
        rd_reg(3'h0, v);
        chk_word(v, en, "frozen");
        rd_reg(3'h3, v);
        chk_word(v, 16'h00c5, "sw pointer");
        // A reset in mid-run clears every register and the request.
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        en = '0;
        en2 = '0;
        st2 = '0;
        rd_reg(3'h1, v);
        chk_word(v, st2, "reset status2");
        chk_word(16'(ptr), 16'h0000, "reset pointer");
        check_irq();
        end_sim();
    end
endmodule

`default_nettype wire
